// ---- cdsw_pkg.sv ----
// constants, word layout and link states of the current dac serial word port
package cdsw_pkg;

    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CODE_W = 10;

    // bit counter values inside one nine-clock byte slot
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE  = 4'h1;
    localparam logic [3:0] BIT_CNT_ACK  = 4'h8;

    // seven-bit address 0001100, two lowest bits ignored: upper five bits compared
    localparam logic [4:0] DEV_ADDR_HI  = 5'h03;
    localparam int         ADDR_HI_MSB  = 7;
    localparam int         ADDR_HI_LSB  = 3;
    localparam int         RW_POS       = 0;
    localparam logic       RW_READ      = 1'b1;

    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
    localparam logic              PD_RESET   = 1'b0;

    // input word: top bit power-down, one spare, ten-bit code, four spare
    typedef struct packed {
        logic              soft_powerdown_bit;
        logic              spare_hi;
        logic [CODE_W-1:0] dac_code;
        logic [3:0]        spare_lo;
    } cdsw_word_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ADDR  = 2'b01,
        ST_WRITE = 2'b10,
        ST_READ  = 2'b11
    } cdsw_link_e;

endpackage

// ---- cdsw_sync.sv ----
// two-flop level synchroniser into the system clock
`timescale 1ns/1ns
module cdsw_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// ---- cdsw_load.sv ----
// system-clock side: takes a finished word and loads the dac code register
`timescale 1ns/1ns
module cdsw_load
    import cdsw_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              tog_sync,
    input  wire cdsw_word_s        xfer_word,
    output logic      [CODE_W-1:0] dac_code,
    output logic                   soft_powerdown_bit,
    output logic                   dac_load
);
    logic              tog_prev_q;
    logic              load;
    logic [CODE_W-1:0] code_q;
    logic              pd_q;
    logic              load_q;

    // word bus is held in the link domain until the next full write, so it is stable here
    assign load = tog_sync ^ tog_prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_prev_q <= 1'b0;
        end else begin
            tog_prev_q <= tog_sync;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            code_q <= CODE_RESET;
            pd_q   <= PD_RESET;
        end else if (load) begin
            code_q <= xfer_word.dac_code;
            pd_q   <= xfer_word.soft_powerdown_bit;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_q <= 1'b0;
        end else begin
            load_q <= load;
        end
    end

    assign dac_code           = code_q;
    assign soft_powerdown_bit = pd_q;
    assign dac_load           = load_q;

    AST_CODE_MAP: assert property (@(posedge clk) disable iff (!rstn)
        load |=> dac_code == $past(xfer_word.dac_code) && dac_load)
        else $error("dac code not taken from word bits 13 to 4");
    AST_PD_MAP: assert property (@(posedge clk) disable iff (!rstn)
        load |=> soft_powerdown_bit == $past(xfer_word.soft_powerdown_bit))
        else $error("power-down not taken from word bit 15");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !load |=> $stable(dac_code) && $stable(soft_powerdown_bit) && !dac_load)
        else $error("dac register changed without a complete write");
    AST_SPARE_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
        load && xfer_word.dac_code == dac_code
            && xfer_word.soft_powerdown_bit == soft_powerdown_bit
        |=> $stable(dac_code) && $stable(soft_powerdown_bit))
        else $error("spare word bits changed the output");
    COV_POWERDOWN: cover property (@(posedge clk) disable iff (!rstn)
        load && xfer_word.soft_powerdown_bit);
endmodule

// ---- cdsw_port.sv ----
// two-wire serial word port of a ten-bit current-sink dac
`timescale 1ns/1ns
module cdsw_port
    import cdsw_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              scl,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    output logic      [CODE_W-1:0] dac_code,
    output logic                   soft_powerdown_bit,
    output logic                   dac_load
);
    cdsw_link_e        st_q;
    logic [3:0]        cnt_q;
    logic              byte_q;
    logic [BYTE_W-1:0] addr_sh_q;
    logic [WORD_W-1:0] serial_input_word_q;
    logic [WORD_W-1:0] rd_sh_q;
    logic              wr_tog_q;
    cdsw_word_s        xfer_q;
    logic              start_q;
    logic              start_seen_q;
    logic              start_clr_n;
    logic              sda_oe_q;
    logic              tog_sync;
    logic              addr_hit;
    logic              ack_slot;
    logic              data_slot;
    logic              wr_done;
    logic              rd_done;

    assign addr_hit  = addr_sh_q[ADDR_HI_MSB:ADDR_HI_LSB] == DEV_ADDR_HI;
    assign ack_slot  = (cnt_q == BIT_CNT_ACK) && !start_q;
    assign data_slot = (cnt_q != BIT_CNT_ACK) && !start_q;
    assign wr_done   = (st_q == ST_WRITE) && ack_slot && byte_q;
    assign rd_done   = (st_q == ST_READ) && ack_slot && byte_q;

    // start: sda falls while scl high; scl stands still here, so sda itself clocks the flag
    always_ff @(negedge sda_i or negedge start_clr_n) begin
        if (!start_clr_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= scl;
        end
    end

    // flag is dropped once the first address bit has seen it
    assign start_clr_n = rstn & ~start_seen_q;

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            start_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_q;
        end
    end

    // link state machine on rising scl; a start always wins over the current state
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            st_q   <= ST_IDLE;
            cnt_q  <= BIT_CNT_ZERO;
            byte_q <= 1'b0;
        end else if (start_q) begin
            st_q   <= ST_ADDR;
            cnt_q  <= BIT_CNT_ONE;
            byte_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= BIT_CNT_ZERO;
                end
                ST_ADDR: begin
                    if (cnt_q == BIT_CNT_ACK) begin
                        cnt_q <= BIT_CNT_ZERO;
                        if (!addr_hit) begin
                            st_q <= ST_IDLE;
                        end else if (addr_sh_q[RW_POS] == RW_READ) begin
                            st_q <= ST_READ;
                        end else begin
                            st_q <= ST_WRITE;
                        end
                    end else begin
                        cnt_q <= cnt_q + BIT_CNT_ONE;
                    end
                end
                ST_WRITE, ST_READ: begin
                    if (cnt_q == BIT_CNT_ACK) begin
                        cnt_q  <= BIT_CNT_ZERO;
                        byte_q <= 1'b1;
                        if (byte_q) begin
                            st_q <= ST_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + BIT_CNT_ONE;
                    end
                end
                default: begin
                    st_q  <= ST_IDLE;
                    cnt_q <= BIT_CNT_ZERO;
                end
            endcase
        end
    end

    // address byte, first bit arrives together with the start flag
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            addr_sh_q <= '0;
        end else if (start_q) begin
            addr_sh_q <= {{(BYTE_W-1){1'b0}}, sda_i};
        end else if (st_q == ST_ADDR && data_slot) begin
            addr_sh_q <= {addr_sh_q[BYTE_W-2:0], sda_i};
        end
    end

    // input word: shifted msb first during writes, cleared after a read
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            serial_input_word_q <= WORD_RESET;
        end else if (st_q == ST_WRITE && data_slot) begin
            serial_input_word_q <= {serial_input_word_q[WORD_W-2:0], sda_i};
        end else if (rd_done) begin
            serial_input_word_q <= WORD_RESET;
        end
    end

    // read shifter loaded at the address acknowledge, leaves upper byte first
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            rd_sh_q <= WORD_RESET;
        end else if (st_q == ST_ADDR && ack_slot) begin
            rd_sh_q <= serial_input_word_q;
        end else if (st_q == ST_READ && data_slot) begin
            rd_sh_q <= {rd_sh_q[WORD_W-2:0], 1'b0};
        end
    end

    // finished word is frozen here so the other domain can sample it after the toggle
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            wr_tog_q <= 1'b0;
            xfer_q   <= cdsw_word_s'(WORD_RESET);
        end else if (wr_done) begin
            wr_tog_q <= ~wr_tog_q;
            xfer_q   <= cdsw_word_s'(serial_input_word_q);
        end
    end

    // sda changes only while scl is low
    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                ST_ADDR:  sda_oe_q <= (cnt_q == BIT_CNT_ACK) && addr_hit;
                ST_WRITE: sda_oe_q <= (cnt_q == BIT_CNT_ACK);
                ST_READ:  sda_oe_q <= (cnt_q != BIT_CNT_ACK) && !rd_sh_q[WORD_W-1];
                default:  sda_oe_q <= 1'b0;
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_q;

    cdsw_sync #(
        .W (1)
    ) u_tog_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (wr_tog_q),
        .q    (tog_sync)
    );

    cdsw_load u_load (
        .clk                (clk),
        .rstn               (rstn),
        .tog_sync           (tog_sync),
        .xfer_word          (xfer_q),
        .dac_code           (dac_code),
        .soft_powerdown_bit (soft_powerdown_bit),
        .dac_load           (dac_load)
    );

    AST_ADDR_ACK: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_ADDR && ack_slot && addr_hit |-> sda_oe_q)
        else $error("own address not acknowledged");
    AST_ADDR_MISS: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_ADDR && ack_slot && !addr_hit |-> !sda_oe_q ##1 st_q == ST_IDLE)
        else $error("foreign address acknowledged or followed");
    AST_DATA_ACK: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_WRITE && ack_slot |-> sda_oe_q)
        else $error("written data byte not acknowledged");
    AST_SHIFT_IN: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_WRITE && data_slot
        |=> serial_input_word_q[0] == $past(sda_i)
            && serial_input_word_q[WORD_W-1:1] == $past(serial_input_word_q[WORD_W-2:0]))
        else $error("write bit not shifted in msb first");
    AST_READ_BIT: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_READ && data_slot |-> sda_oe_q == !rd_sh_q[WORD_W-1])
        else $error("read bit on sda does not follow the word");
    AST_READ_LOAD: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_ADDR && ack_slot |=> rd_sh_q == $past(serial_input_word_q))
        else $error("read shifter not loaded from the input word");
    AST_READ_CLEAR: assert property (@(posedge scl) disable iff (!rstn)
        rd_done |=> serial_input_word_q == WORD_RESET && st_q == ST_IDLE)
        else $error("input word not cleared after read");
    AST_LOAD_AFTER_TWO: assert property (@(posedge scl) disable iff (!rstn)
        wr_done |=> wr_tog_q != $past(wr_tog_q)
            && xfer_q == cdsw_word_s'($past(serial_input_word_q)))
        else $error("complete write did not hand over the word");
    AST_NO_EARLY_LOAD: assert property (@(posedge scl) disable iff (!rstn)
        !wr_done |=> $stable(wr_tog_q) && $stable(xfer_q))
        else $error("word handed over before second byte");
    AST_TWO_BYTES: assert property (@(posedge scl) disable iff (!rstn)
        (st_q == ST_WRITE || st_q == ST_READ) && ack_slot && !byte_q
        |=> byte_q && st_q == $past(st_q) && cnt_q == BIT_CNT_ZERO)
        else $error("transaction ended after one data byte");
    AST_NO_THIRD: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_IDLE |-> !sda_oe_q)
        else $error("sda driven outside a transaction");

    // framing: a start restarts the engine from any state, even mid-byte
    AST_START_RESTARTS: assert property (@(posedge scl) disable iff (!rstn)
        start_q |=> st_q == ST_ADDR && cnt_q == BIT_CNT_ONE && !byte_q)
        else $error("start did not restart the address phase");

    // flag must be gone by the second address bit, else every bit restarts the frame
    AST_START_ONCE: assert property (@(posedge scl) disable iff (!rstn)
        start_q |=> !start_q)
        else $error("start flag still set at the second address bit");

    AST_CNT_RANGE: assert property (@(posedge scl) disable iff (!rstn)
        cnt_q <= BIT_CNT_ACK)
        else $error("bit counter outside the nine-clock byte slot");

    AST_IDLE_STAYS: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_IDLE && !start_q |=> st_q == ST_IDLE)
        else $error("engine left idle without a start");

    AST_IDLE_HOLDS_WORD: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_IDLE && !start_q |=> $stable(serial_input_word_q))
        else $error("input word changed outside a transaction");

    AST_ADDR_SHIFT: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_ADDR && data_slot
        |=> addr_sh_q == {$past(addr_sh_q[BYTE_W-2:0]), $past(sda_i)})
        else $error("address bit not shifted in msb first");

    AST_ADDR_TO_DATA: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_ADDR && ack_slot && addr_hit
        |=> cnt_q == BIT_CNT_ZERO && !byte_q && st_q != ST_IDLE
            && (st_q == ST_READ) == ($past(addr_sh_q[RW_POS]) == RW_READ))
        else $error("matched address did not open the right data phase");

    // the master owns sda during its own bits
    AST_MASTER_BITS_FREE: assert property (@(posedge scl) disable iff (!rstn)
        (st_q == ST_ADDR || st_q == ST_WRITE) && data_slot |-> !sda_oe_q)
        else $error("sda pulled while the master sends a bit");

    AST_SECOND_BYTE_ACK: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_WRITE && byte_q && ack_slot |-> sda_oe_q)
        else $error("second written data byte not acknowledged");

    AST_READ_ACK_FREE: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_READ && ack_slot |-> !sda_oe_q)
        else $error("sda pulled in the master acknowledge slot of a read");

    AST_READ_SHIFT: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_READ && data_slot |=> rd_sh_q == {$past(rd_sh_q[WORD_W-2:0]), 1'b0})
        else $error("read shifter did not advance one bit");

    AST_READ_KEEPS_WORD: assert property (@(posedge scl) disable iff (!rstn)
        st_q == ST_READ && !rd_done |=> $stable(serial_input_word_q))
        else $error("input word changed before the read completed");

    AST_WRITE_ENDS: assert property (@(posedge scl) disable iff (!rstn)
        wr_done |=> st_q == ST_IDLE && !sda_oe_q)
        else $error("engine still busy after the second data byte");

    // one clk pulse per word; a double pulse means the toggle was taken twice
    AST_LOAD_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        dac_load |=> !dac_load)
        else $error("dac load pulse longer than one cycle");

    COV_WRITE: cover property (@(posedge scl) disable iff (!rstn) wr_done);
    COV_READ: cover property (@(posedge scl) disable iff (!rstn) rd_done);
    COV_MISS: cover property (@(posedge scl) disable iff (!rstn)
        st_q == ST_ADDR && ack_slot && !addr_hit);
    COV_LOAD: cover property (@(posedge clk) disable iff (!rstn) dac_load);
endmodule

// ---- cdsw_master_model.sv ----
// behavioural two-wire bus master that drives the dac serial word port
`timescale 1ns/1ns
module cdsw_master_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // scl stands high between frames; data moves an eighth of a period after scl falls
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start();
        if (scl === 1'b0) begin
            #8 sda_low = 1'b0;
            #24 scl = 1'b1;
        end
        #16 sda_low = 1'b1;
        #16 scl = 1'b0;
    endtask

    task automatic stop();
        #8 sda_low = 1'b1;
        #24 scl = 1'b1;
        #16 sda_low = 1'b0;
        #16;
    endtask

    // one scl period; sda sampled in the middle of the high phase
    task automatic clk_bit(input logic b, output logic s);
        #8 sda_low = ~b;
        #24 scl = 1'b1;
        #16 s = sda;
        #16 scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask

    // last byte of a read gets a nack so the device lets go of sda
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(last, s);
    endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench of the dac serial word port
`timescale 1ns/1ns
module tb_top;
    import cdsw_pkg::*;

    logic              clk;
    logic              rstn;
    logic              scl;
    logic              sda_low;
    logic              sda_o;
    logic              sda_oe;
    wire               sda_wire;
    logic [CODE_W-1:0] dac_code;
    logic              soft_powerdown_bit;
    logic              dac_load;
    int                num_errors;
    int                comparisons;
    int                loads;
    int                exp_loads;
    logic [15:0]       cur_word;

    // open drain with pull-up: low if either party pulls
    assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~sda_low;

    cdsw_port u_cdsw_port (
        .clk                (clk),
        .rstn               (rstn),
        .scl                (scl),
        .sda_i              (sda_wire),
        .sda_o              (sda_o),
        .sda_oe             (sda_oe),
        .dac_code           (dac_code),
        .soft_powerdown_bit (soft_powerdown_bit),
        .dac_load           (dac_load)
    );

    cdsw_master_model u_cdsw_master_model (
        .scl     (scl),
        .sda_low (sda_low),
        .sda     (sda_wire)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // falling edge: dac_load has settled for the whole cycle
    always @(negedge clk) begin
        if (dac_load === 1'b1) loads++;
    end

    function automatic logic [15:0] exp_code(input logic [15:0] w);
        return {6'h00, w[13:4]};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_write(input logic [7:0] a, input logic [15:0] w, input int nb,
                            output logic [2:0] acks);
        u_cdsw_master_model.start();
        u_cdsw_master_model.send_byte(a, acks[2]);
        u_cdsw_master_model.send_byte(w[15:8], acks[1]);
        acks[0] = 1'b0;
        if (nb > 1) u_cdsw_master_model.send_byte(w[7:0], acks[0]);
        u_cdsw_master_model.stop();
    endtask

    task automatic do_read(input logic [7:0] a, output logic [15:0] w, output logic ack);
        u_cdsw_master_model.start();
        u_cdsw_master_model.send_byte(a, ack);
        u_cdsw_master_model.recv_byte(1'b0, w[15:8]);
        u_cdsw_master_model.recv_byte(1'b1, w[7:0]);
        u_cdsw_master_model.stop();
    endtask

    // bounded wait for the synchroniser, then compare the dac outputs
    task automatic settle_and_check();
        for (int i = 0; i < 20 && loads != exp_loads; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk(dac_code, exp_code(cur_word));
        chk(soft_powerdown_bit, cur_word[15]);
        chk(16'(loads), 16'(exp_loads));
    endtask

    initial begin
        #500000;
        num_errors++;
        conclude();
    end

    initial begin
        logic [15:0] w;
        logic [15:0] rd;
        logic [2:0]  acks;
        logic        ack;
        logic [15:0] corners [4];
        rstn = 1'b0;
        corners = '{16'hffff, 16'h400f, 16'h8000, 16'h7ff0};
        num_errors = 0;
        comparisons = 0;
        loads = 0;
        exp_loads = 0;
        cur_word = 16'h0000;
        void'($urandom(47855));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk(sda_oe, 1'b0);
        chk(sda_o, 1'b0);
        settle_and_check();
        for (int i = 0; i < 12; i++) begin
            w = (i < 4) ? corners[i] : 16'($urandom());
            // every ignored-bit variant of the address must be answered
            do_write(8'h18 | 8'((i % 4) << 1), w, 2, acks);
            chk(acks, 3'b111);
            cur_word = w;
            exp_loads++;
            settle_and_check();
            if (i % 3 == 0) begin
                do_read(8'h19 | 8'((i % 4) << 1), rd, ack);
                chk(ack, 1'b1);
                chk(rd, w);
                do_read(8'h19, rd, ack);
                chk(rd, 16'h0000);
                settle_and_check();
            end
        end
        // address outside the ignored bits: nobody answers
        do_write(8'h20, 16'h1230, 2, acks);
        chk(acks, 3'b000);
        do_write(8'h10, 16'h1230, 2, acks);
        chk(acks, 3'b000);
        settle_and_check();
        // write cut after the first data byte
        do_write(8'h18, ~cur_word, 1, acks);
        chk(acks, 3'b110);
        settle_and_check();
        // back to back full write after the aborted one
        w = 16'($urandom());
        do_write(8'h1e, w, 2, acks);
        chk(acks, 3'b111);
        cur_word = w;
        exp_loads++;
        settle_and_check();
        conclude();
    end
endmodule
